// file: shared/tioc_pkg.sv
package tioc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int STRB_W  = 4;

    // register byte addresses, one aligned word each
    localparam logic [7:0] REG_CTRL  = 8'h00;   // operation mode
    localparam logic [7:0] REG_START = 8'h04;   // start current setting in percent
    localparam logic [7:0] REG_LIVE  = 8'h08;   // live trip flags, read only
    localparam logic [7:0] REG_EVENT = 8'h0c;   // sticky on/off events, cleared by read
    localparam logic [7:0] REG_MASK  = 8'h10;   // interrupt mask, same layout as events

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // operation mode field, ctrl bits [1:0]
    localparam int         MODE_W    = 2;
    localparam logic [1:0] MODE_OFF  = 2'h0;
    localparam logic [1:0] MODE_PEAK = 2'h1;
    localparam logic [1:0] MODE_FUND = 2'h2;

    // start current field, start bits [11:0]
    localparam int          START_W   = 12;
    localparam int          THR_W     = 13;
    localparam logic [11:0] START_MIN = 12'h014;
    localparam logic [11:0] START_MAX = 12'hbb8;
    localparam logic [11:0] START_DEF = 12'h0c8;

    // measured quantities, same percent scale as the start setting
    localparam int MEAS_W = 16;

    // drop-out ratio 0.85 expressed as 17/20
    localparam int          CALC_W   = 24;
    localparam logic [23:0] DROP_NUM = 24'h000011;
    localparam logic [23:0] DROP_DEN = 24'h000014;

    // event field layout
    localparam int NUM_TRIP    = 4;
    localparam int EVT_W       = 8;
    localparam int EVT_ON_LSB  = 0;
    localparam int EVT_OFF_LSB = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // the four trip flags travel together
    typedef struct packed {
        logic gen;
        logic p3;
        logic p2;
        logic p1;
    } tioc_trips_s;

endpackage

// file: design/tioc_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1 - inhibit input forces every trip flag low
// R2 - doubler input doubles the start threshold
// R3 - one trip flag per phase above threshold
// R4 - general trip is any phase tripped
// R5 - each trip change logs on/off event
// R6 - live trip flags readable as status
// R7 - peak mode: 0.85 dropout, fast trip, reset
// R8 - fundamental mode: 0.85 dropout, trip, reset
// R9 - trip decision without added delay
// R10 - mode selects off, peak or fundamental
// R11 - start setting 20 to 3000, default 200
// R12 - pickup needs strictly greater than threshold
// R13 - mode off holds all trips low
module tioc_top (
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite write address
    input  wire logic [tioc_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]                    s_axi_awprot,
    input  wire logic                          s_axi_awvalid,
    output wire logic                          s_axi_awready,
    // axi4-lite write data
    input  wire logic [tioc_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [tioc_pkg::STRB_W-1:0]   s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output wire logic                          s_axi_wready,
    // axi4-lite write response
    output logic      [1:0]                    s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    // axi4-lite read address
    input  wire logic [tioc_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]                    s_axi_arprot,
    input  wire logic                          s_axi_arvalid,
    output wire logic                          s_axi_arready,
    // axi4-lite read data
    output logic      [tioc_pkg::DATA_W-1:0]   s_axi_rdata,
    output logic      [1:0]                    s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // user binary inputs
    input  wire logic                          protection_inhibit_in,
    input  wire logic                          setting_doubler_in,
    // measured quantities from preprocessing
    input  wire logic [tioc_pkg::MEAS_W-1:0]   phase1_fundamental_rms,
    input  wire logic [tioc_pkg::MEAS_W-1:0]   phase2_fundamental_rms,
    input  wire logic [tioc_pkg::MEAS_W-1:0]   phase3_fundamental_rms,
    input  wire logic [tioc_pkg::MEAS_W-1:0]   phase1_peak_value,
    input  wire logic [tioc_pkg::MEAS_W-1:0]   phase2_peak_value,
    input  wire logic [tioc_pkg::MEAS_W-1:0]   phase3_peak_value,
    // trip outputs
    output wire logic                          phase1_trip,
    output wire logic                          phase2_trip,
    output wire logic                          phase3_trip,
    output wire logic                          any_phase_trip,
    // interrupt
    output logic                               irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    // word address of a byte address
    function automatic logic [tioc_pkg::ADDR_W-1:0] word_of(
        input logic [tioc_pkg::ADDR_W-1:0] a
    );
        word_of = {a[tioc_pkg::ADDR_W-1:2], 2'h0};
    endfunction

    // true for an address that holds a register
    function automatic logic is_mapped(input logic [tioc_pkg::ADDR_W-1:0] a);
        logic [tioc_pkg::ADDR_W-1:0] w;
        w = word_of(a);
        is_mapped = (w == tioc_pkg::REG_CTRL) || (w == tioc_pkg::REG_START) ||
                    (w == tioc_pkg::REG_LIVE) || (w == tioc_pkg::REG_EVENT) ||
                    (w == tioc_pkg::REG_MASK);
    endfunction

    // keep the start setting inside its legal range
    function automatic logic [tioc_pkg::START_W-1:0] clamp_start(
        input logic [tioc_pkg::START_W-1:0] v
    );
        if (v < tioc_pkg::START_MIN) begin
            clamp_start = tioc_pkg::START_MIN;
        end else if (v > tioc_pkg::START_MAX) begin
            clamp_start = tioc_pkg::START_MAX;
        end else begin
            clamp_start = v;
        end
    endfunction

    // one phase: strict pickup when idle, hold until below 0.85 of threshold
    function automatic logic phase_decide(
        input logic                        held,
        input logic [tioc_pkg::MEAS_W-1:0] m,
        input logic [tioc_pkg::THR_W-1:0]  t
    );
        logic [tioc_pkg::CALC_W-1:0] m_wide;
        logic [tioc_pkg::CALC_W-1:0] t_wide;
        logic [tioc_pkg::CALC_W-1:0] m_scaled;
        logic [tioc_pkg::CALC_W-1:0] t_scaled;
        m_wide   = tioc_pkg::CALC_W'(m);
        t_wide   = tioc_pkg::CALC_W'(t);
        m_scaled = tioc_pkg::CALC_W'(m_wide * tioc_pkg::DROP_DEN);
        t_scaled = tioc_pkg::CALC_W'(t_wide * tioc_pkg::DROP_NUM);
        if (held) begin
            phase_decide = !(m_scaled < t_scaled);   // [R7] [R8]
        end else begin
            phase_decide = m_wide > t_wide;          // [R12]
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // registers and internal signals
    logic [tioc_pkg::MODE_W-1:0]  mode;
    logic [tioc_pkg::START_W-1:0] start_pct;
    logic [tioc_pkg::EVT_W-1:0]   evt;
    logic [tioc_pkg::EVT_W-1:0]   evt_mask;
    tioc_pkg::tioc_trips_s        trips;
    tioc_pkg::tioc_trips_s        next_trips;
    logic [tioc_pkg::EVT_W-1:0]   next_evt;
    logic [tioc_pkg::THR_W-1:0]   threshold;
    logic                         func_on;
    logic [tioc_pkg::MEAS_W-1:0]  meas1;
    logic [tioc_pkg::MEAS_W-1:0]  meas2;
    logic [tioc_pkg::MEAS_W-1:0]  meas3;
    logic                         aw_held;
    logic                         w_held;
    logic [tioc_pkg::ADDR_W-1:0]  aw_addr;
    logic [tioc_pkg::DATA_W-1:0]  w_data;
    logic [tioc_pkg::STRB_W-1:0]  w_strb;
    logic                         do_write;
    logic                         do_read;
    logic                         rd_evt_clear;
    logic [tioc_pkg::START_W-1:0] start_merged;
    logic [tioc_pkg::DATA_W-1:0]  rd_word;

    ////////////////////////////////////////////////////////////////////////////////
    // axi write channel: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;

    // capture write address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    // capture write data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // write response, error for unmapped address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= tioc_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(aw_addr) ? tioc_pkg::RESP_OKAY : tioc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // start setting merged byte by byte before clamping
    assign start_merged = {w_strb[1] ? w_data[11:8] : start_pct[11:8],
                           w_strb[0] ? w_data[7:0]  : start_pct[7:0]};

    ////////////////////////////////////////////////////////////////////////////////
    // settings registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode      <= tioc_pkg::MODE_OFF;                     // [R10]
            start_pct <= tioc_pkg::START_DEF;                    // [R11]
            evt_mask  <= '0;
        end else if (do_write) begin
            if (word_of(aw_addr) == tioc_pkg::REG_CTRL && w_strb[0]) begin
                mode <= w_data[tioc_pkg::MODE_W-1:0];            // [R10]
            end
            if (word_of(aw_addr) == tioc_pkg::REG_START && (|w_strb[1:0])) begin
                start_pct <= clamp_start(start_merged);          // [R11]
            end
            if (word_of(aw_addr) == tioc_pkg::REG_MASK && w_strb[0]) begin
                evt_mask <= w_data[tioc_pkg::EVT_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign do_read       = s_axi_arvalid && s_axi_arready;
    assign rd_evt_clear  = do_read && (word_of(s_axi_araddr) == tioc_pkg::REG_EVENT);

    // read multiplexer, unused bits read zero
    always_comb begin
        rd_word = '0;
        case (word_of(s_axi_araddr))
            tioc_pkg::REG_CTRL:  rd_word[tioc_pkg::MODE_W-1:0]   = mode;
            tioc_pkg::REG_START: rd_word[tioc_pkg::START_W-1:0]  = start_pct;
            tioc_pkg::REG_LIVE:  rd_word[tioc_pkg::NUM_TRIP-1:0] = trips;      // [R6]
            tioc_pkg::REG_EVENT: rd_word[tioc_pkg::EVT_W-1:0]    = evt;        // [R5]
            tioc_pkg::REG_MASK:  rd_word[tioc_pkg::EVT_W-1:0]    = evt_mask;
            default:             rd_word = '0;
        endcase
    end

    // read data held until accepted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= tioc_pkg::RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= is_mapped(s_axi_araddr) ? tioc_pkg::RESP_OKAY
                                                    : tioc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // instantaneous decision
    assign threshold = setting_doubler_in ? {start_pct, 1'b0}           // [R2]
                                          : {1'b0, start_pct};
    assign func_on   = ((mode == tioc_pkg::MODE_PEAK) || (mode == tioc_pkg::MODE_FUND)) &&
                       !protection_inhibit_in;                           // [R1] [R13]
    assign meas1     = (mode == tioc_pkg::MODE_PEAK) ? phase1_peak_value   // [R10]
                                                     : phase1_fundamental_rms;
    assign meas2     = (mode == tioc_pkg::MODE_PEAK) ? phase2_peak_value
                                                     : phase2_fundamental_rms;
    assign meas3     = (mode == tioc_pkg::MODE_PEAK) ? phase3_peak_value
                                                     : phase3_fundamental_rms;

    // per-phase flags and their union
    always_comb begin
        next_trips.p1  = func_on && phase_decide(trips.p1, meas1, threshold);   // [R3]
        next_trips.p2  = func_on && phase_decide(trips.p2, meas2, threshold);   // [R3]
        next_trips.p3  = func_on && phase_decide(trips.p3, meas3, threshold);   // [R3]
        next_trips.gen = next_trips.p1 || next_trips.p2 || next_trips.p3;      // [R4]
    end

    // trip flags updated every cycle, one cycle from input to output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trips <= '0;
        end else begin
            trips <= next_trips;                                 // [R9] [R7] [R8]
        end
    end

    assign phase1_trip    = trips.p1;
    assign phase2_trip    = trips.p2;
    assign phase3_trip    = trips.p3;
    assign any_phase_trip = trips.gen;

    ////////////////////////////////////////////////////////////////////////////////
    // events: on in low nibble, off in high nibble; a new event beats the read clear
    always_comb begin
        next_evt = rd_evt_clear ? '0 : evt;
        next_evt[tioc_pkg::EVT_ON_LSB +: tioc_pkg::NUM_TRIP] =
            next_evt[tioc_pkg::EVT_ON_LSB +: tioc_pkg::NUM_TRIP] | (next_trips & ~trips);   // [R5]
        next_evt[tioc_pkg::EVT_OFF_LSB +: tioc_pkg::NUM_TRIP] =
            next_evt[tioc_pkg::EVT_OFF_LSB +: tioc_pkg::NUM_TRIP] | (trips & ~next_trips);  // [R5]
    end

    // sticky event register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt <= '0;
        end else begin
            evt <= next_evt;                                     // [R5]
        end
    end

    // interrupt level from unmasked events
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_evt & evt_mask);
        end
    end

endmodule

// file: testbench/tioc_asserts.sv
`timescale 1ns/1ps
// watches trip, interrupt and bus handshake ports of the top
module tioc_asserts (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    // decision path
    input wire logic        protection_inhibit_in,
    input wire logic [15:0] phase1_peak_value,
    input wire logic [15:0] phase1_fundamental_rms,
    input wire logic        phase1_trip,
    input wire logic        phase2_trip,
    input wire logic        phase3_trip,
    input wire logic        any_phase_trip,
    input wire logic        irq
);
    logic [3:0] trips;

    // trip flags gathered for change detection
    assign trips = {any_phase_trip, phase3_trip, phase2_trip, phase1_trip};

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////////
    any_trip_or_a:
        assert property (any_phase_trip == (|trips[2:0]))
        else $error("general trip differs from phase trips");
    inhibit_clear_a:
        assert property (protection_inhibit_in |=> trips == 4'h0)
        else $error("trip seen while inhibited");
    pickup_min_a:
        assert property ($rose(phase1_trip) |-> $past(phase1_peak_value) > 16'h0014 ||
                         $past(phase1_fundamental_rms) > 16'h0014)
        else $error("phase1 picked up at or below the lowest threshold");
    irq_rise_a:
        assert property ($rose(irq) |-> trips != $past(trips) || $past(s_axi_bvalid))
        else $error("interrupt rose with no trip change or write");
    irq_fall_a:
        assert property ($fell(irq) |-> $rose(s_axi_rvalid) || $past(s_axi_bvalid))
        else $error("interrupt fell with no read or write");
    read_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not returned one cycle after address");
    read_refuse_a:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    write_answer_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                         |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response timing wrong");
endmodule

bind tioc_top tioc_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .protection_inhibit_in, .phase1_peak_value, .phase1_fundamental_rms,
    .phase1_trip, .phase2_trip, .phase3_trip, .any_phase_trip, .irq);

// file: testbench/tioc_meas_model.sv
`timescale 1ns/1ps
// measurement front end: one register stage, like the preprocessing
module tioc_meas_model (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // commanded quantities, index 0 is phase1
    input  wire logic [2:0][15:0] peak_cmd,
    input  wire logic [2:0][15:0] fund_cmd,
    // quantities towards the decision block
    output logic      [2:0][15:0] peak_out,
    output logic      [2:0][15:0] fund_out
);
    // outputs cleared in reset, follow commands one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            peak_out <= '0;
            fund_out <= '0;
        end else begin
            peak_out <= peak_cmd;
            fund_out <= fund_cmd;
        end
    end
endmodule

// file: testbench/tioc_tb_top.sv
`timescale 1ns/1ps
module tioc_tb_top;
    logic             aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]       s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]      s_axi_wdata = '0, s_axi_rdata;
    logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic             s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, inh = 1'b0, dbl = 1'b0;
    logic [1:0]       s_axi_bresp, s_axi_rresp;
    logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic             p1, p2, p3, anyt, irq;
    logic [2:0][15:0] pk = '0, fd = '0, pko, fdo;
    logic [33:0]      rq[$], bq[$];
    logic [31:0]      seed = 32'h49a2515f;
    int               n_mismatch = 0, samples_checked = 0;

    initial forever #12.5 aclk = ~aclk;

    tioc_meas_model u_meas (.aclk, .aresetn, .peak_cmd(pk), .fund_cmd(fd),
        .peak_out(pko), .fund_out(fdo));

    tioc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .protection_inhibit_in(inh), .setting_doubler_in(dbl),
        .phase1_fundamental_rms(fdo[0]), .phase2_fundamental_rms(fdo[1]),
        .phase3_fundamental_rms(fdo[2]), .phase1_peak_value(pko[0]),
        .phase2_peak_value(pko[1]), .phase3_peak_value(pko[2]), .phase1_trip(p1),
        .phase2_trip(p2), .phase3_trip(p3), .any_phase_trip(anyt), .irq);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xrand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [33:0] e, input logic [33:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    // one edge of a bounded wait
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 60) begin
            n_mismatch++;
            results();
        end
    endtask

    // write: address and data offered together, bready held until response
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = tioc_pkg::RESP_OKAY);
        bit aw, w, b;
        int n;
        n = 0;
        bq.push_back({32'h0, r});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w && b)) begin
            tick(n);
            aw = aw | s_axi_awready;
            w = w | s_axi_wready;
            b = b | s_axi_bvalid;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
            s_axi_bready <= !b;
        end
    endtask

    // read: rready raised with the address and held until rvalid is seen
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] r = tioc_pkg::RESP_OKAY);
        bit ar, rv;
        int n;
        n = 0;
        rq.push_back({e, r});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!(ar && rv)) begin
            tick(n);
            ar = ar | s_axi_arready;
            rv = rv | (s_axi_rvalid & s_axi_rready);
            s_axi_arvalid <= !ar;
            s_axi_rready <= !rv;
        end
    endtask

    // measurements first, binary inputs one edge later so both land together
    task automatic apply(input logic [47:0] p, input logic [47:0] f, input logic d,
                         input logic i);
        @(posedge aclk);
        pk <= p;
        fd <= f;
        @(posedge aclk);
        dbl <= d;
        inh <= i;
        repeat (3) @(posedge aclk);
    endtask

    task automatic pins(input logic [3:0] e);
        cmp("trips", {30'h0, e}, {30'h0, anyt, p3, p2, p1});
    endtask

    // response watcher takes the oldest note for each answer
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready)
            cmp("read", rq.pop_front(), {s_axi_rdata, s_axi_rresp});
        if (s_axi_bvalid && s_axi_bready)
            cmp("write resp", bq.pop_front(), {32'h0, s_axi_bresp});
    end

    initial begin
        repeat (60000) @(posedge aclk);
        n_mismatch++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [23:0] cl[4];
        logic [47:0] p, f;
        logic [31:0] r1, r2;
        logic [3:0]  st;
        logic        d, i;
        int          q, thr;
        cl = '{24'h005014, 24'hfa0bb8, 24'h4d24d2, 24'h0c80c8};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(tioc_pkg::REG_CTRL, 32'h0);
        rd(tioc_pkg::REG_START, 32'hc8);
        rd(tioc_pkg::REG_LIVE, 32'h0);
        rd(tioc_pkg::REG_EVENT, 32'h0);
        rd(tioc_pkg::REG_MASK, 32'h0);
        rd(8'h20, 32'h0, tioc_pkg::RESP_SLVERR);
        wr(8'h20, 32'h1, tioc_pkg::RESP_SLVERR);
        $display("reset values done");
        foreach (cl[k]) begin
            wr(tioc_pkg::REG_START, {20'h0, cl[k][23:12]});
            rd(tioc_pkg::REG_START, {20'h0, cl[k][11:0]});
        end
        $display("start clamp done");
        for (int m = 0; m < 4; m++) begin
            wr(tioc_pkg::REG_CTRL, 32'(m));
            for (int s = 0; s < 2; s++) begin
                apply(s ? 48'h0 : 48'd300, s ? 48'd300 : 48'h0, 1'b0, 1'b0);
                pins((m == 1 && s == 0) || (m == 2 && s == 1) ? 4'h9 : 4'h0);
                apply('0, '0, 1'b0, 1'b0);
            end
        end
        rd(tioc_pkg::REG_EVENT, 32'h99);
        $display("mode select done");
        wr(tioc_pkg::REG_CTRL, 32'h1);
        wr(tioc_pkg::REG_MASK, 32'hff);
        apply(48'd200, '0, 1'b0, 1'b0);
        pins(4'h0);
        apply(48'd201, '0, 1'b0, 1'b0);
        pins(4'h9);
        cmp("irq", 34'h1, {33'h0, irq});
        rd(tioc_pkg::REG_LIVE, 32'h9);
        apply(48'd170, '0, 1'b0, 1'b0);
        pins(4'h9);
        apply(48'd169, '0, 1'b0, 1'b0);
        pins(4'h0);
        rd(tioc_pkg::REG_EVENT, 32'h99);
        cmp("irq", 34'h0, {33'h0, irq});
        $display("boundary done");
        apply({16'h0, 16'd400, 16'h0}, '0, 1'b1, 1'b0);
        pins(4'h0);
        apply({16'h0, 16'd401, 16'h0}, '0, 1'b1, 1'b0);
        pins(4'ha);
        apply({16'h0, 16'd401, 16'h0}, '0, 1'b1, 1'b1);
        pins(4'h0);
        apply('0, '0, 1'b0, 1'b0);
        wr(tioc_pkg::REG_MASK, 32'h0);
        $display("doubler inhibit done");
        for (int m = 1; m < 3; m++) begin
            wr(tioc_pkg::REG_CTRL, 32'(m));
            st = 4'h0;
            repeat (150) begin
                r1 = xrand();
                r2 = xrand();
                p = {7'h0, r1[26:18], 7'h0, r1[17:9], 7'h0, r1[8:0]};
                f = {7'h0, r2[26:18], 7'h0, r2[17:9], 7'h0, r2[8:0]};
                d = r2[27];
                i = &r2[31:29];
                thr = d ? 400 : 200;
                for (int k = 0; k < 3; k++) begin
                    q = m == 1 ? int'(p[16*k +: 16]) : int'(f[16*k +: 16]);
                    st[k] = !i && (st[k] ? q * 20 >= thr * 17 : q > thr);
                end
                st[3] = |st[2:0];
                apply(p, f, d, i);
                pins(st);
            end
            apply('0, '0, 1'b0, 1'b0);
        end
        $display("random done");
        results();
    end
endmodule
